/* shared/rid_alu_if.sv */
// Purpose: carries operands and results between the sequencer and the alu
// Assumes: purely combinational consumer
// Notes: flags holds the incoming status, flagsOut the updated one
`timescale 1ns/1ps
interface rid_alu_if;
  logic [13:0] instr;
  logic [7:0] acc;
  logic [7:0] fileVal;
  logic [7:0] flags;
  logic [7:0] result;
  logic [7:0] flagsOut;
  logic toAcc;
  logic toFile;
  logic skipCond;
  modport seq (output instr, acc, fileVal, flags, input result, flagsOut, toAcc, toFile,
    skipCond);
  modport alu (input instr, acc, fileVal, flags, output result, flagsOut, toAcc, toFile,
    skipCond);
endinterface : rid_alu_if

/* shared/rid_pkg.sv */
// Purpose: constants and types shared by the 14-bit instruction decoder block
// Assumes: 50 MHz system clock, one oscillator period per clock
// Notes: opcode constants are whole instruction words, matched against all 14 bits
package rid_pkg;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam int PC_W = 13;
  localparam logic [6:0] ADDR_TIMER = 7'h01;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_PORTA = 7'h05;
  localparam logic [6:0] ADDR_PORTB = 7'h06;
  localparam logic [6:0] ADDR_PORTC = 7'h07;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETINT = 14'h0009;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_WDTCLR = 14'h0064;
  localparam logic [13:0] OP_CLRW = 14'h0103;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLP = 3;
  localparam int ST_WDX = 4;
  // expiry and sleep flags read one out of reset
  localparam logic [7:0] ST_RST = 8'h18;

  typedef enum logic [1:0] {CTL_NONE, CTL_PUSH, CTL_POP} rid_stk_t;
endpackage : rid_pkg

/* src/rid_alu.sv */
// Purpose: data operations and flag effects of one decoded instruction
// Assumes: operands stable during the execute phase
// Notes: control instructions other than the literal return leave result unused
`timescale 1ns/1ps
module rid_alu
  import rid_pkg::*;
(
  // sequencer side
  rid_alu_if.alu bus
);
  // add with carry and half carry, returns {c, dc, sum}
  function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : addc

  logic [13:0] i;
  logic [7:0] f;
  logic [7:0] w;
  logic [7:0] k;
  logic [9:0] s;
  logic [7:0] mask;
  assign i = bus.instr;
  assign f = bus.fileVal;
  assign w = bus.acc;
  assign k = i[7:0];
  assign mask = 8'h01 << i[9:7];

  // decode and execute
  always_comb begin
    bus.result = 8'h00;
    bus.flagsOut = bus.flags;
    bus.toAcc = 1'b0;
    bus.toFile = 1'b0;
    bus.skipCond = 1'b0;
    s = 10'h000;
    case (i[13:12])
      2'h0: begin
        bus.toAcc = ~i[7];
        bus.toFile = i[7];
        case (i[11:8])
          4'h7: begin
            s = addc(w, f, 1'b0);
            bus.result = s[7:0];
            bus.flagsOut[ST_C] = s[9];
            bus.flagsOut[ST_DC] = s[8];
          end
          4'h2: begin
            s = addc(f, ~w, 1'b1);
            bus.result = s[7:0];
            bus.flagsOut[ST_C] = s[9];
            bus.flagsOut[ST_DC] = s[8];
          end
          4'h5: bus.result = w & f;
          4'h4: bus.result = w | f;
          4'h6: bus.result = w ^ f;
          4'h1: bus.result = 8'h00;
          4'h9: bus.result = ~f;
          4'h3: bus.result = f - 8'h01;
          4'hA: bus.result = f + 8'h01;
          4'h8: bus.result = f;
          4'hD: begin
            bus.result = {f[6:0], bus.flags[ST_C]};
            bus.flagsOut[ST_C] = f[7];
          end
          4'hC: begin
            bus.result = {bus.flags[ST_C], f[7:1]};
            bus.flagsOut[ST_C] = f[0];
          end
          4'hE: bus.result = {f[3:0], f[7:4]};
          4'hB: begin
            bus.result = f - 8'h01;
            bus.skipCond = (bus.result == 8'h00);
          end
          4'hF: begin
            bus.result = f + 8'h01;
            bus.skipCond = (bus.result == 8'h00);
          end
          default: begin
            // move accumulator to file, or control word
            bus.result = w;
            bus.toAcc = 1'b0;
            bus.toFile = i[7];
          end
        endcase
        // zero flag for the byte ops that own it
        if (i[11:8] inside {4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h1, 4'h9, 4'h3, 4'hA, 4'h8}) begin
          bus.flagsOut[ST_Z] = (bus.result == 8'h00);
        end
        if (i == OP_CLRW) begin
          bus.toAcc = 1'b1;
          bus.toFile = 1'b0;
        end
      end
      2'h1: begin
        case (i[11:10])
          2'h0: begin
            bus.result = f & ~mask;
            bus.toFile = 1'b1;
          end
          2'h1: begin
            bus.result = f | mask;
            bus.toFile = 1'b1;
          end
          2'h2: bus.skipCond = ((f & mask) == 8'h00);
          default: bus.skipCond = ((f & mask) != 8'h00);
        endcase
      end
      2'h3: begin
        bus.toAcc = 1'b1;
        casez (i[11:8])
          4'b00??, 4'b01??: bus.result = k;
          4'b111?: begin
            s = addc(w, k, 1'b0);
            bus.result = s[7:0];
            bus.flagsOut[ST_C] = s[9];
            bus.flagsOut[ST_DC] = s[8];
            bus.flagsOut[ST_Z] = (s[7:0] == 8'h00);
          end
          4'b110?: begin
            s = addc(k, ~w, 1'b1);
            bus.result = s[7:0];
            bus.flagsOut[ST_C] = s[9];
            bus.flagsOut[ST_DC] = s[8];
            bus.flagsOut[ST_Z] = (s[7:0] == 8'h00);
          end
          4'b1001: begin
            bus.result = w & k;
            bus.flagsOut[ST_Z] = (bus.result == 8'h00);
          end
          4'b1000: begin
            bus.result = w | k;
            bus.flagsOut[ST_Z] = (bus.result == 8'h00);
          end
          4'b1010: begin
            bus.result = w ^ k;
            bus.flagsOut[ST_Z] = (bus.result == 8'h00);
          end
          default: bus.toAcc = 1'b0;
        endcase
      end
      default: ;
    endcase
  end
endmodule : rid_alu

/* src/rid_core.sv */
// Purpose: fetch, decode and execute sequencer for 14-bit instructions
// Assumes: program memory answers combinationally to progAddr; file data read same phase
// Notes: one instruction cycle is four clocks; writes are decided on the last phase and land in the next phase 0, with cycleStart
`timescale 1ns/1ps
module rid_core
  import rid_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // program memory
  output logic [PC_W-1:0] progAddr,
  input wire logic [13:0] progData,
  // file register port
  output logic [6:0] fileAddr,
  input wire logic [7:0] fileRdLatch,
  input wire logic [7:0] portPins,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  // configuration
  input wire logic [1:0] upperAddrLatch,
  input wire logic prescalerToTimer,
  // status and side effects
  output logic [7:0] accOut,
  output logic [7:0] statusOut,
  output logic prescalerClr,
  output logic watchdogClr,
  output logic sleepReq,
  output logic cycleStart
);
  logic rstMeta_r;
  logic rstN;
  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  logic [7:0] pinMeta_r;
  logic [7:0] pinSync_r;
  // pins are asynchronous; only the second stage feeds the operand mux
  always_ff @(posedge clk_sys) begin
    pinMeta_r <= portPins;
    pinSync_r <= pinMeta_r;
  end

  logic [1:0] phase_r, phase_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [13:0] ir_r, ir_nxt;
  logic flush_r, flush_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] st_r, st_nxt;
  logic [6:0] fa_r, fa_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic we_r, we_nxt;
  logic pclr_r, pclr_nxt;
  logic wclr_r, wclr_nxt;
  logic slp_r, slp_nxt;
  logic cs_r, cs_nxt;
  rid_stk_t stkOp;
  logic [PC_W-1:0] stackTop;
  logic isPort;
  logic [7:0] opnd;
  logic lastPh;

  // control decodes shared by the sequencer and its checks
  function automatic logic isJump(input logic [13:0] w);
    return w[13:11] == 3'b101;
  endfunction : isJump

  function automatic logic isCall(input logic [13:0] w);
    return w[13:11] == 3'b100;
  endfunction : isCall

  // literal return matches whatever sits in its two x bits
  function automatic logic isReturn(input logic [13:0] w);
    return w == OP_RETURN || w == OP_RETINT || w[13:10] == 4'hD;
  endfunction : isReturn

  rid_alu_if aluBus ();
  rid_alu uAlu (.bus(aluBus.alu));
  rid_stack uStack (.clk_sys(clk_sys), .rstN(rstN), .op(stkOp), .pushVal(pc_r),
    .stackTop(stackTop));

  assign lastPh = (phase_r == PHASE_LAST);
  assign isPort = (ir_r[6:0] == ADDR_PORTA) || (ir_r[6:0] == ADDR_PORTB)
    || (ir_r[6:0] == ADDR_PORTC);
  assign opnd = isPort ? pinSync_r : (ir_r[6:0] == ADDR_STATUS) ? st_r : fileRdLatch;
  assign aluBus.instr = flush_r ? OP_NOP : ir_r;
  assign aluBus.acc = acc_r;
  assign aluBus.fileVal = opnd;
  assign aluBus.flags = st_r;

  // sequencer next state
  always_comb begin
    phase_nxt = phase_r + 2'h1;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    flush_nxt = flush_r;
    acc_nxt = acc_r;
    st_nxt = st_r;
    fa_nxt = ir_r[6:0];
    wd_nxt = aluBus.result;
    we_nxt = 1'b0;
    pclr_nxt = 1'b0;
    wclr_nxt = 1'b0;
    slp_nxt = 1'b0;
    cs_nxt = 1'b0;
    stkOp = CTL_NONE;
    if (lastPh) begin
      cs_nxt = 1'b1;
      ir_nxt = progData;
      pc_nxt = pc_r + 13'h0001;
      flush_nxt = 1'b0;
      if (!flush_r) begin
        if (aluBus.toAcc) begin
          acc_nxt = aluBus.result;
        end
        st_nxt = aluBus.flagsOut;
        if (aluBus.toFile) begin
          we_nxt = 1'b1;
          pclr_nxt = (ir_r[6:0] == ADDR_TIMER) && prescalerToTimer;
        end
        if (aluBus.skipCond) begin
          flush_nxt = 1'b1;
        end
        if (isJump(ir_r)) begin
          pc_nxt = {upperAddrLatch, ir_r[10:0]};
          flush_nxt = 1'b1;
        end
        if (isCall(ir_r)) begin
          stkOp = CTL_PUSH;
          pc_nxt = {upperAddrLatch, ir_r[10:0]};
          flush_nxt = 1'b1;
        end
        // x bits of literal return ignored
        if (isReturn(ir_r)) begin
          stkOp = CTL_POP;
          pc_nxt = stackTop;
          flush_nxt = 1'b1;
        end
        if (ir_r == OP_SLEEP) begin
          st_nxt[ST_WDX] = 1'b1;
          st_nxt[ST_SLP] = 1'b0;
          slp_nxt = 1'b1;
        end
        if (ir_r == OP_WDTCLR) begin
          st_nxt[ST_WDX] = 1'b1;
          st_nxt[ST_SLP] = 1'b1;
          wclr_nxt = 1'b1;
        end
      end
      // taken change forces a no-op cycle
      if (flush_nxt) begin
        ir_nxt = OP_NOP;
      end
    end
  end

  // register all sequencer state
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      phase_r <= 2'h0;
      pc_r <= PC_RST;
      ir_r <= OP_NOP;
      flush_r <= 1'b0;
      acc_r <= ACC_RST;
      st_r <= ST_RST;
      fa_r <= 7'h00;
      wd_r <= 8'h00;
      we_r <= 1'b0;
      pclr_r <= 1'b0;
      wclr_r <= 1'b0;
      slp_r <= 1'b0;
      cs_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
      flush_r <= flush_nxt;
      acc_r <= acc_nxt;
      st_r <= st_nxt;
      fa_r <= fa_nxt;
      wd_r <= wd_nxt;
      we_r <= we_nxt;
      pclr_r <= pclr_nxt;
      wclr_r <= wclr_nxt;
      slp_r <= slp_nxt;
      cs_r <= cs_nxt;
    end
  end

  // program address is the counter flop; file address tracks the instruction
  assign progAddr = pc_r;
  assign fileAddr = fa_r;
  assign fileWrData = wd_r;
  assign fileWrEn = we_r;
  assign accOut = acc_r;
  assign statusOut = st_r;
  assign prescalerClr = pclr_r;
  assign watchdogClr = wclr_r;
  assign sleepReq = slp_r;
  assign cycleStart = cs_r;

  // checks look one edge after the deciding phase-3 edge
  // cycle pulse every four clocks
  a_cycle_period: assert property (@(posedge clk_sys) disable iff (!rstN)
    cs_r |=> !cs_r [*3] ##1 cs_r)
    else $error("cycle pulse not every four clocks");
  // side pulses only at a boundary
  a_pulse_align: assert property (@(posedge clk_sys) disable iff (!rstN)
    we_r || pclr_r || wclr_r || slp_r |-> cs_r)
    else $error("pulse away from a cycle boundary");
  a_jump_target: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && isJump(ir_r)
    |=> pc_r == {$past(upperAddrLatch), $past(ir_r[10:0])} && flush_r)
    else $error("jump target wrong");
  a_call_push: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && isCall(ir_r) |=> stackTop == $past(pc_r) && flush_r
    && pc_r == {$past(upperAddrLatch), $past(ir_r[10:0])})
    else $error("call push or target wrong");
  a_ret_pop: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && isReturn(ir_r) |=> pc_r == $past(stackTop) && flush_r)
    else $error("return target wrong");
  a_ret_literal: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:10] == 4'hD |=> acc_r == $past(ir_r[7:0]))
    else $error("literal return value wrong");
  a_flush_nowrite: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && flush_r |=> !we_r && acc_r == $past(acc_r) && st_r == $past(st_r))
    else $error("no-op cycle wrote");
  a_skip_flush: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && aluBus.skipCond |=> flush_r && ir_r == OP_NOP)
    else $error("taken skip kept the prefetched word");
  a_pre_clear: assert property (@(posedge clk_sys) disable iff (!rstN)
    pclr_r |-> we_r && fa_r == ADDR_TIMER)
    else $error("prescaler clear without timer write");
  a_wdt_flags: assert property (@(posedge clk_sys) disable iff (!rstN)
    wclr_r |-> st_r[ST_WDX] && st_r[ST_SLP])
    else $error("watchdog clear flags wrong");
  a_sleep_flags: assert property (@(posedge clk_sys) disable iff (!rstN)
    slp_r |-> st_r[ST_WDX] && !st_r[ST_SLP])
    else $error("standby flags wrong");
  a_pc_advance: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_nxt && stkOp == CTL_NONE && ir_r[13:12] != 2'h2
    |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("counter did not advance");
  a_fetch_load: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_nxt |=> ir_r == $past(progData))
    else $error("fetched word not loaded");
  a_port_pins: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && isPort && ir_r[13:7] == 7'h11 |=> we_r && wd_r == $past(pinSync_r))
    else $error("port write-back not from pins");
  // destination one writes file, zero keeps file
  a_dest_file: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:12] == 2'h0 && ir_r[11:8] == 4'h7 |=> we_r == $past(ir_r[7]))
    else $error("destination routing wrong");
  a_dest_keep: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:12] == 2'h0 && ir_r[7] |=> acc_r == $past(acc_r))
    else $error("file destination changed accumulator");
  // bit clear or set keeps status
  a_bit_flags: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:11] == 3'b010 |=> we_r && st_r == $past(st_r))
    else $error("bit write wrong");
  a_zero_and: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:8] == 6'h39 |=> st_r[ST_Z] == (acc_r == 8'h00))
    else $error("and literal zero flag wrong");
  a_add_zero: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:9] == 5'h1F |=> st_r[ST_Z] == (acc_r == 8'h00))
    else $error("add literal zero flag wrong");
  a_sub_zero: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:9] == 5'h1E |=> st_r[ST_Z] == (acc_r == 8'h00))
    else $error("subtract literal zero flag wrong");
  a_swap_flags: assert property (@(posedge clk_sys) disable iff (!rstN)
    lastPh && !flush_r && ir_r[13:8] == 6'h0E |=> st_r == $past(st_r))
    else $error("nibble exchange changed status");
endmodule : rid_core

/* src/rid_stack.sv */
// Purpose: eight-level return address stack
// Assumes: push and pop never together
// Notes: wraps silently on overflow, like a circular buffer
`timescale 1ns/1ps
module rid_stack
  import rid_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstN,
  // control
  input wire rid_stk_t op,
  input wire logic [PC_W-1:0] pushVal,
  output logic [PC_W-1:0] stackTop
);
  logic [PC_W-1:0] mem [8];
  logic [2:0] ptr_r;
  logic [2:0] ptr_nxt;
  // pointer next value
  always_comb begin
    case (op)
      CTL_PUSH: ptr_nxt = ptr_r + 3'h1;
      CTL_POP: ptr_nxt = ptr_r - 3'h1;
      default: ptr_nxt = ptr_r;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ptr_r <= 3'h0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end
  // storage needs no reset
  always_ff @(posedge clk_sys) begin
    if (op == CTL_PUSH) begin
      mem[ptr_nxt] <= pushVal;
    end
  end
  assign stackTop = mem[ptr_r];
endmodule : rid_stack

/* verification/rid_prog_mem.sv */
// Purpose: program memory model feeding instruction words to the sequencer
// Assumes: answers combinationally to the fetch address, no wait states
// Notes: unloaded words read as no-operation
`timescale 1ns/1ps
module rid_prog_mem
  import rid_pkg::*;
(
  // fetch side
  input wire logic [PC_W-1:0] progAddr,
  output logic [13:0] progData
);
  logic [13:0] mem [0:8191];

  // cleared to no-operation so stray fetches stay harmless
  initial begin
    foreach (mem[i]) mem[i] = OP_NOP;
  end

  // combinational answer, the sequencer samples it on its own phase
  assign progData = mem[progAddr];
endmodule : rid_prog_mem

/* verification/testbench.sv */
// Purpose: self-checking bench for the 14-bit instruction sequencer
// Assumes: results, write pulses and side pulses land together with cycleStart
// Notes: a reference interpreter predicts every instruction cycle, idle ones too
`timescale 1ns/1ps
module testbench
  import rid_pkg::*;
;
  localparam logic [15:0] ZMASK = 16'h077A;
  localparam logic [6:0] FTAB [8] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h20, 7'h21, 7'h22, 7'h7F};
  localparam logic [3:0] LIT [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD,
    4'hE, 4'hF};
  logic clk_sys, nrst, fileWrEn, prescalerToTimer, prescalerClr, watchdogClr, sleepReq;
  logic cycleStart;
  logic [PC_W-1:0] progAddr;
  logic [13:0] progData;
  logic [6:0] fileAddr;
  logic [7:0] fileRdLatch, portPins, fileWrData, accOut, statusOut, acc, st;
  logic [1:0] upperAddrLatch;
  logic [7:0] fmem [0:127];
  logic [7:0] mmem [0:127];
  logic [PC_W-1:0] stk [0:7];
  logic [31:0] seed;
  logic [47:0] q [$];
  int fails, tests_run, pc, sp;

  rid_core dut_u (.clk_sys(clk_sys), .nrst(nrst), .progAddr(progAddr), .progData(progData),
    .fileAddr(fileAddr), .fileRdLatch(fileRdLatch), .portPins(portPins),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn), .upperAddrLatch(upperAddrLatch),
    .prescalerToTimer(prescalerToTimer), .accOut(accOut), .statusOut(statusOut),
    .prescalerClr(prescalerClr), .watchdogClr(watchdogClr), .sleepReq(sleepReq),
    .cycleStart(cycleStart));
  rid_prog_mem pm_u (.progAddr(progAddr), .progData(progData));

  // file space seen by the design, updated only by its own writes
  assign fileRdLatch = fmem[fileAddr];

  // 50 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // one expected instruction cycle: fetch address, acc, status, write, pulses
  task automatic put(input int pa, input logic [18:0] io);
    q.push_back({PC_W'(pa), acc, st, io});
  endtask : put

  // add or subtract against the accumulator; borrow shows as a cleared carry
  task automatic arith(input logic [7:0] x, input logic sub, output logic [7:0] r);
    logic [8:0] s;
    logic [4:0] h;
    s = sub ? {1'h0, x} - {1'h0, acc} : {1'h0, x} + {1'h0, acc};
    h = sub ? {1'h0, x[3:0]} - {1'h0, acc[3:0]} : {1'h0, x[3:0]} + {1'h0, acc[3:0]};
    r = s[7:0];
    st[ST_C] = s[8] ^ sub;
    st[ST_DC] = h[4] ^ sub;
    st[ST_Z] = (s[7:0] == 8'h00);
  endtask : arith

  // reference interpreter: executes the word at pc and queues its cycles
  task automatic exec();
    logic [13:0] w;
    logic [7:0] fv;
    logic [7:0] r;
    logic [6:0] f;
    logic [3:0] op;
    logic we;
    logic skip;
    logic two;
    logic [1:0] pls;
    int nx;
    w = pm_u.mem[pc];
    f = w[6:0];
    op = w[11:8];
    fv = (f >= ADDR_PORTA && f <= ADDR_PORTC) ? portPins : mmem[f];
    r = fv;
    we = 1'h0;
    skip = 1'h0;
    two = 1'h0;
    pls = 2'h0;
    nx = pc + 1;
    if (w[13:12] == 2'h0) begin
      case (op)
        4'h0: r = acc;
        4'h1: r = 8'h00;
        4'h2: arith(fv, 1'h1, r);
        4'h3, 4'hB: r = fv - 8'h01;
        4'h4: r = acc | fv;
        4'h5: r = acc & fv;
        4'h6: r = acc ^ fv;
        4'h7: arith(fv, 1'h0, r);
        4'h9: r = ~fv;
        4'hA, 4'hF: r = fv + 8'h01;
        4'hC: {r, st[ST_C]} = {st[ST_C], fv};
        4'hD: {st[ST_C], r} = {fv, st[ST_C]};
        4'hE: r = {fv[3:0], fv[7:4]};
        default: r = fv;
      endcase
      if (ZMASK[op]) st[ST_Z] = (r == 8'h00);
      skip = (op == 4'hB || op == 4'hF) && r == 8'h00;
      if (op == 4'h0 && !w[7]) begin
        if (w[7:1] == 7'h04) begin
          sp = (sp + 7) % 8;
          nx = stk[sp];
          two = 1'h1;
        end
        if (w[7:0] == 8'h63) {st[ST_WDX], st[ST_SLP], pls} = 4'h9;
        if (w[7:0] == 8'h64) {st[ST_WDX], st[ST_SLP], pls} = 4'hE;
      end else if (w[7]) we = 1'h1;
      else acc = r;
    end else if (w[13:12] == 2'h1) begin
      r[w[9:7]] = w[10];
      we = !w[11];
      skip = w[11] && fv[w[9:7]] == w[10];
    end else if (w[13:12] == 2'h2) begin
      if (!w[11]) begin
        stk[sp] = PC_W'(pc + 1);
        sp = (sp + 1) % 8;
      end
      nx = {upperAddrLatch, w[10:0]};
      two = 1'h1;
    end else begin
      casez (op)
        4'b00??: acc = w[7:0];
        4'b01??: begin
          acc = w[7:0];
          sp = (sp + 7) % 8;
          nx = stk[sp];
          two = 1'h1;
        end
        4'h8: acc = acc | w[7:0];
        4'h9: acc = acc & w[7:0];
        4'hA: acc = acc ^ w[7:0];
        4'b110?: arith(w[7:0], 1'h1, acc);
        default: arith(w[7:0], 1'h0, acc);
      endcase
      if (op[3:2] == 2'h2) st[ST_Z] = (acc == 8'h00);
    end
    if (we) mmem[f] = r;
    if (skip) nx = pc + 2;
    if (skip || two) put(nx, {we, we ? f : 7'h00, we ? r : 8'h00,
      we && f == ADDR_TIMER && prescalerToTimer, pls});
    if (skip || two) put(nx + 1, 19'h0);
    else put(nx + 1, {we, we ? f : 7'h00, we ? r : 8'h00,
      we && f == ADDR_TIMER && prescalerToTimer, pls});
    pc = nx;
  endtask : exec

  // main sequence: random program, directed calls and jumps, per-cycle compare
  initial begin : main_seq
    logic [31:0] x;
    logic [13:0] w;
    logic [47:0] e;
    logic [12:0] u;
    int n;
    seed = 32'hB5676963;
    fails = 0;
    tests_run = 0;
    pc = 0;
    sp = 0;
    acc = ACC_RST;
    st = ST_RST;
    nrst = 1'h0;
    portPins = 8'h00;
    prescalerToTimer = 1'h0;
    x = rnd();
    upperAddrLatch = x[1:0];
    u = {upperAddrLatch, 11'h000};
    foreach (fmem[i]) begin
      x = rnd();
      fmem[i] = x[7:0];
      mmem[i] = x[7:0];
    end
    // random straight-line code with don't-care bits filled at random
    for (int a = 0; a < 80; a++) begin
      x = rnd();
      case (x[5:3])
        3'h4, 3'h5: w = {2'h1, x[9:8], x[15:13], FTAB[x[2:0]]};
        3'h6: w = {2'h3, LIT[x[19:16] % 4'hB], x[27:20]};
        3'h7: w = x[6] ? OP_SLEEP : OP_WDTCLR;
        default: w = {2'h0, x[11:8], x[12], FTAB[x[2:0]]};
      endcase
      if (w[13:7] == 7'h00) w = {6'h00, 1'h0, x[14:13], 5'h00};
      if (w[13:7] == 7'h02) w = OP_CLRW;
      pm_u.mem[a] = w;
    end
    // port write-back, calls into each return kind, then a jump into the upper page
    pm_u.mem[80] = 14'h0886;
    pm_u.mem[81] = 14'h2100;
    pm_u.mem[82] = 14'h2110;
    pm_u.mem[83] = 14'h2120;
    pm_u.mem[84] = 14'h2A00;
    pm_u.mem[u + 13'h0100] = 14'h345A;
    pm_u.mem[u + 13'h0110] = OP_RETURN;
    pm_u.mem[u + 13'h0120] = OP_RETINT;
    pm_u.mem[u + 13'h0200] = 14'h2A00;
    repeat (2) @(negedge clk_sys);
    nrst = 1'h1;
    put(1, 19'h0);
    for (int i = 0; i < 170; i++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (cycleStart !== 1'h1 && n < 16);
      if (cycleStart !== 1'h1) begin
        fails++;
        break;
      end
      if (i > 0) check(n, 4);
      e = q.pop_front();
      check(progAddr, e[47:35]);
      check({accOut, statusOut}, e[34:19]);
      check({fileWrEn, fileWrEn ? {fileAddr, fileWrData} : 15'h0}, e[18:3]);
      check({prescalerClr, watchdogClr, sleepReq}, e[2:0]);
      if (fileWrEn === 1'h1) fmem[fileAddr] = fileWrData;
      if (q.size() == 0) begin
        x = rnd();
        portPins = x[7:0];
        prescalerToTimer = x[8];
        exec();
      end
    end
    conclude();
  end
endmodule : testbench
